// *** mpss_pkg.sv ***
// Constants and types for the module power and sleep sequencer
package mpss_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned PON_MIN_MS    = 25;
  localparam int unsigned RAIL_MAX_MS   = 25;
  localparam int unsigned ERST_MIN_MS   = 10;
  localparam int unsigned PON_CYC       = PON_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned ERST_CYC      = ERST_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned RAIL_MAX_CYC  = RAIL_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned IDLE_CYC      = 1000;
  // Two sync, state and output flops between pin fall and rail good
  localparam int unsigned PON_LAT       = 4;
  localparam int unsigned CNT_W         = 32;

  localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS   = 32'h0000_0004;

  localparam logic [1:0]  SLEEP_DTR     = 2'h0;
  localparam logic [1:0]  SLEEP_AUTO    = 2'h1;
  localparam logic [1:0]  SLEEP_NEVER   = 2'h2;

  localparam int unsigned CTRL_OFF_BIT  = 0;
  localparam int unsigned CTRL_CFG_LSB  = 4;
  localparam int unsigned CTRL_BUSY_BIT = 8;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  typedef enum {
    MPSS_OFF,
    MPSS_RUN,
    MPSS_SLEEP
  } mpss_state_t;

  typedef struct packed {
    logic       on;
    logic       sleeping;
    logic       lna_low_gain;
    logic       wiped;
    logic [1:0] sleep_cfg;
  } mpss_status_t;
endpackage

// *** mpss_lowpulse.sv ***
// Synchronised low-level pin with a minimum-width qualifier
`timescale 1ns/1ns
module mpss_lowpulse
  import mpss_pkg::*;
#(
  parameter int unsigned MIN_CYC = 10
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic pin_n_in,
  output logic      low_out,
  output logic      qual_out
);
  logic             sync1;
  logic [CNT_W-1:0] cnt;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1   <= 1'b1;
      low_out <= 1'b0;
    end else begin
      sync1   <= pin_n_in;
      low_out <= ~sync1;
    end
  end

  // Saturating width count, pulses once per qualifying low
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt      <= '0;
      qual_out <= 1'b0;
    end else if (!low_out) begin
      cnt      <= '0;
      qual_out <= 1'b0;
    end else begin
      if (cnt < CNT_W'(MIN_CYC)) begin
        cnt <= cnt + CNT_W'(1);
      end
      qual_out <= (cnt == CNT_W'(MIN_CYC - 1));
    end
  end
endmodule

// *** mpss_top.sv ***
// Power-on, switch-off, emergency shutdown and sleep control with AHB-Lite registers
`timescale 1ns/1ns

module mpss_top
  import mpss_pkg::*;
#(
  parameter int unsigned PON_CYCLES  = PON_CYC,
  parameter int unsigned ERST_CYCLES = ERST_CYC,
  parameter int unsigned IDLE_CYCLES = IDLE_CYC
) (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        POWER_ON_REQUEST_N_IN,
  input  wire logic        EMERGENCY_RESET_N_IN,
  input  wire logic        DTR_N_IN,
  input  wire logic        LNA_GAIN_STRAP_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  output logic             IO_RAIL_GOOD_OUT,
  output logic             SLEEP_OUT,
  output logic             LNA_LOW_GAIN_OUT,
  output logic             WIPE_OUT
);
  mpss_state_t      state;
  logic             pon_low;
  logic             pon_qual;
  logic             erst_low;
  logic             erst_qual;
  logic             dtr_s1;
  logic             dtr_high;
  logic             strap_s1;
  logic             strap_s2;
  logic             strap_done;
  logic             lna_low;
  logic [1:0]       sleep_cfg;
  logic             tasks_busy;
  logic             off_cmd;
  logic             wiped;
  logic [CNT_W-1:0] idle_cnt;
  logic             idle_done;
  logic             wr_pend;
  logic             rd_pend;
  logic [31:0]      ph_addr;
  logic             ph_go;
  mpss_status_t     status;

  // width qualifier, shortened by the pipeline latency
  // so the rail is good no later than PON_CYCLES after the pin falls
  mpss_lowpulse #(.MIN_CYC(PON_CYCLES - PON_LAT)) u_pon (
    .clk_in   (SYS_CLK_IN),
    .rst_in   (RST_IN),
    .pin_n_in (POWER_ON_REQUEST_N_IN),
    .low_out  (pon_low),
    .qual_out (pon_qual)
  );

  mpss_lowpulse #(.MIN_CYC(ERST_CYCLES)) u_erst (
    .clk_in   (SYS_CLK_IN),
    .rst_in   (RST_IN),
    .pin_n_in (EMERGENCY_RESET_N_IN),
    .low_out  (erst_low),
    .qual_out (erst_qual)
  );

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      dtr_s1   <= 1'b1;
      dtr_high <= 1'b1;
    end else begin
      dtr_s1   <= DTR_N_IN;
      dtr_high <= dtr_s1;
    end
  end

  // Strap sync runs through reset; reset must span two edges to settle it
  always_ff @(posedge SYS_CLK_IN) begin
    strap_s1 <= LNA_GAIN_STRAP_IN;
    strap_s2 <= strap_s1;
  end

  // strap sensed once after reset release
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      strap_done <= 1'b0;
      lna_low    <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      lna_low    <= ~strap_s2;
    end
  end

  // Power state machine
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      state <= MPSS_OFF;
      wiped <= 1'b0;
    end else begin
      case (state)
        MPSS_OFF: begin
          if (pon_qual && !erst_low) begin
            state <= MPSS_RUN;
            wiped <= 1'b0;
          end
        end
        MPSS_RUN, MPSS_SLEEP: begin
          if (erst_qual && !pon_low) begin
            state <= MPSS_OFF;
            wiped <= 1'b1;
          end else if (off_cmd && !pon_low) begin
            state <= MPSS_OFF;
          end else if (sleep_cfg == SLEEP_NEVER) begin
            state <= MPSS_RUN;
          end else if (sleep_cfg == SLEEP_DTR) begin
            if (!dtr_high) begin
              state <= MPSS_RUN;
            end else if (idle_done) begin
              state <= MPSS_SLEEP;
            end
          end else if (sleep_cfg == SLEEP_AUTO) begin
            state <= tasks_busy ? MPSS_RUN : MPSS_SLEEP;
          end else begin
            state <= MPSS_RUN;
          end
        end
        default: state <= MPSS_OFF;
      endcase
    end
  end

  // idle delay, cancelled by DTR low
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      idle_cnt  <= '0;
      idle_done <= 1'b0;
    end else if (state != MPSS_RUN || !dtr_high || sleep_cfg != SLEEP_DTR) begin
      idle_cnt  <= '0;
      idle_done <= 1'b0;
    end else if (idle_cnt < CNT_W'(IDLE_CYCLES - 1)) begin
      idle_cnt <= idle_cnt + CNT_W'(1);
    end else begin
      idle_done <= 1'b1;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      IO_RAIL_GOOD_OUT <= 1'b0;
      SLEEP_OUT        <= 1'b0;
      LNA_LOW_GAIN_OUT <= 1'b0;
      WIPE_OUT         <= 1'b0;
    end else begin
      // rail follows state, not the pin
      IO_RAIL_GOOD_OUT <= (state != MPSS_OFF);
      SLEEP_OUT        <= (state == MPSS_SLEEP);
      LNA_LOW_GAIN_OUT <= lna_low;
      WIPE_OUT         <= wiped;
    end
  end

  assign ph_go  = HSEL_IN && HREADY_IN && (HTRANS_IN == HTRANS_NONSEQ);
  assign status = '{on: (state != MPSS_OFF), sleeping: (state == MPSS_SLEEP),
                    lna_low_gain: lna_low, wiped: wiped, sleep_cfg: sleep_cfg};

  // AHB-Lite slave, zero wait states
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      wr_pend       <= 1'b0;
      rd_pend       <= 1'b0;
      ph_addr       <= '0;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end else begin
      wr_pend       <= ph_go && HWRITE_IN;
      rd_pend       <= ph_go && !HWRITE_IN;
      ph_addr       <= ph_go ? HADDR_IN : ph_addr;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end
  end

  // Control register: off command pulse, sleep config, task busy
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      off_cmd    <= 1'b0;
      sleep_cfg  <= SLEEP_DTR;
      tasks_busy <= 1'b0;
    end else begin
      off_cmd <= 1'b0;
      if (wr_pend && ph_addr == ADDR_CTRL) begin
        off_cmd    <= HWDATA_IN[CTRL_OFF_BIT];
        sleep_cfg  <= HWDATA_IN[CTRL_CFG_LSB +: 2];
        tasks_busy <= HWDATA_IN[CTRL_BUSY_BIT];
      end
    end
  end

  // Read data registered at the address phase edge; valid throughout the data phase
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      HRDATA_OUT <= '0;
    end else if (ph_go && !HWRITE_IN) begin
      if (HADDR_IN == ADDR_CTRL) begin
        HRDATA_OUT <= 32'(sleep_cfg) << CTRL_CFG_LSB | 32'(tasks_busy) << CTRL_BUSY_BIT;
      end else if (HADDR_IN == ADDR_STATUS) begin
        HRDATA_OUT <= 32'(status);
      end else begin
        HRDATA_OUT <= 32'h0000_0000;
      end
    end
  end

  // a_rail_on_time: rail good two cycles after qualified request
  a_rail_on_time: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (state == MPSS_OFF && pon_qual && !erst_low) |-> ##2 IO_RAIL_GOOD_OUT)
    else $error("rail good late");
  a_stay_powered: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (state != MPSS_OFF && !erst_qual && !off_cmd) |=> state != MPSS_OFF)
    else $error("module dropped power");
  a_off_ignored: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (state != MPSS_OFF && off_cmd && pon_low && !erst_qual) |=> state != MPSS_OFF)
    else $error("off accepted with request low");
  a_emerg_wipe: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (state != MPSS_OFF && erst_qual && !pon_low) |=> (state == MPSS_OFF && wiped))
    else $error("emergency shutdown missed");
  a_dtr_wake: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (state == MPSS_SLEEP && sleep_cfg == SLEEP_DTR && !dtr_high && !off_cmd && !erst_qual)
    |=> state == MPSS_RUN)
    else $error("no wake on dtr");
  a_auto_sleep: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (state == MPSS_RUN && sleep_cfg == SLEEP_AUTO && !tasks_busy && !off_cmd && !erst_qual)
    |=> state == MPSS_SLEEP)
    else $error("auto sleep missed");
  a_never_sleep: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (state == MPSS_RUN && sleep_cfg == SLEEP_NEVER) |=> state != MPSS_SLEEP)
    else $error("slept in never mode");
  a_lna_strap: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    $rose(strap_done) |-> ##1 (LNA_LOW_GAIN_OUT == ~$past(strap_s2, 2)))
    else $error("lna gain wrong");
  a_idle_cancel: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    !dtr_high |=> (idle_cnt == '0 && !idle_done))
    else $error("idle not cancelled");
  c_power_up: cover property (@(posedge SYS_CLK_IN) $rose(IO_RAIL_GOOD_OUT));
  c_sleep: cover property (@(posedge SYS_CLK_IN) $rose(SLEEP_OUT));
  c_wipe: cover property (@(posedge SYS_CLK_IN) $rose(WIPE_OUT));
endmodule

// *** mpss_host_model.sv ***
// Host-side model driving the power request, emergency reset and DTR pins
`timescale 1ns/1ns
module mpss_host_model (
  input  wire logic clk_in,
  output logic      pon_n_out,
  output logic      erst_n_out,
  output logic      dtr_n_out
);
  // Released request is driven high by the model from time zero
  initial begin
    pon_n_out  = 1'b1;
    erst_n_out = 1'b1;
    dtr_n_out  = 1'b0;
  end
  task automatic drive(input int sel, input logic v);
    @(posedge clk_in);
    case (sel)
      0: pon_n_out <= v;
      1: erst_n_out <= v;
      default: dtr_n_out <= v;
    endcase
  endtask
  task automatic pulse(input int sel, input int n);
    if (sel == 1 && pon_n_out !== 1'b1) drive(0, 1'b1);
    drive(sel, 1'b0);
    repeat (n - 1) @(posedge clk_in);
    drive(sel, 1'b1);
  endtask
endmodule

// *** mpss_top_tb.sv ***
// Self-checking testbench for the power and sleep sequencer
`timescale 1ns/1ns
module mpss_top_tb;
  import mpss_pkg::*;
  localparam int PON  = 20;
  localparam int ERST = 10;
  localparam int IDLE = 8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        strap = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        rail;
  logic        sleep;
  logic        lna;
  logic        wipe;
  logic        pon_n;
  logic        erst_n;
  logic        dtr_n;
  logic [31:0] rdv;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  mpss_top #(.PON_CYCLES(PON), .ERST_CYCLES(ERST), .IDLE_CYCLES(IDLE)) u_mpss_top (
    .SYS_CLK_IN(clk), .RST_IN(rst), .POWER_ON_REQUEST_N_IN(pon_n),
    .EMERGENCY_RESET_N_IN(erst_n), .DTR_N_IN(dtr_n), .LNA_GAIN_STRAP_IN(strap),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .IO_RAIL_GOOD_OUT(rail),
    .SLEEP_OUT(sleep), .LNA_LOW_GAIN_OUT(lna), .WIPE_OUT(wipe));
  mpss_host_model u_mpss_host_model (
    .clk_in(clk), .pon_n_out(pon_n), .erst_n_out(erst_n), .dtr_n_out(dtr_n));
  always #5 clk = ~clk;
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Generous ceiling; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      $display("unexpected at %0t: run timed out", $time);
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic rd_st(input logic [5:0] e, input string m);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rdv, {26'h0, e}, m);
    chk({31'h0, hresp}, 32'h0, "okay response");
  endtask
  // Lo above hi means the level must not appear within hi cycles
  task automatic await_level(input int sel, input logic v, input int lo, input int hi,
                             input string m);
    int   n;
    logic s;
    n = 0;
    for (int i = 1; i <= hi && n == 0; i++) begin
      @(posedge clk);
      #1;
      s = (sel == 0) ? rail : (sel == 1) ? sleep : wipe;
      if (s === v) n = i;
    end
    chk({31'h0, (lo <= hi) ? (n >= lo && n != 0) : (n == 0)}, 32'h1, m);
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk);
    rst <= 1'b1;
    strap <= s;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic power_up();
    u_mpss_host_model.pulse(0, PON + 2);
    await_level(0, 1'b1, 1, 10, "power up");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk({29'h0, hready, rail, hresp}, 32'h4, "reset outputs");
    chk({31'h0, lna}, 32'h1, "strap low gain");
    rd_st(6'b001000, "status after reset");
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rdv, 32'h0, "ctrl after reset");
    bus(1'b0, 32'h0000_0008, 32'h0);
    chk(rdv, 32'h0, "unmapped read");
    $display("test reset done");
    u_mpss_host_model.pulse(0, PON / 2);
    await_level(0, 1'b1, 41, 40, "short request ignored");
    fork
      u_mpss_host_model.pulse(0, PON + 10);
    join_none
    // Rail must be up no later than PON cycles after the pin falls
    await_level(0, 1'b1, PON, PON + 1, "rail good delay");
    await_level(0, 1'b0, 31, 30, "stays on after release");
    u_mpss_host_model.drive(0, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h1);
    await_level(0, 1'b0, 21, 20, "off ignored while requested");
    u_mpss_host_model.drive(0, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h1);
    await_level(0, 1'b0, 1, 10, "orderly off");
    $display("test power on and off done");
    power_up();
    u_mpss_host_model.drive(2, 1'b1);
    repeat (IDLE / 2) @(posedge clk);
    u_mpss_host_model.drive(2, 1'b0);
    await_level(1, 1'b1, 41, 40, "short idle cancelled");
    u_mpss_host_model.drive(2, 1'b1);
    await_level(1, 1'b1, IDLE, IDLE + 8, "dtr idle sleep");
    rd_st(6'b111000, "status sleeping");
    u_mpss_host_model.drive(2, 1'b0);
    await_level(1, 1'b0, 1, 6, "dtr wake");
    bus(1'b1, ADDR_CTRL, 32'h20);
    u_mpss_host_model.drive(2, 1'b1);
    await_level(1, 1'b1, 41, 40, "never sleep");
    rd_st(6'b101010, "status config two");
    bus(1'b1, ADDR_CTRL, 32'h30);
    await_level(1, 1'b1, 21, 20, "config three stays awake");
    bus(1'b1, ADDR_CTRL, 32'h110);
    u_mpss_host_model.drive(2, 1'b0);
    await_level(1, 1'b1, 21, 20, "busy keeps awake");
    bus(1'b1, ADDR_CTRL, 32'h10);
    await_level(1, 1'b1, 1, 10, "auto sleep despite dtr");
    $display("test sleep modes done");
    u_mpss_host_model.pulse(1, ERST / 2);
    await_level(0, 1'b0, 21, 20, "short emergency ignored");
    u_mpss_host_model.pulse(1, ERST);
    await_level(0, 1'b0, 1, 8, "emergency shutdown");
    chk({31'h0, wipe}, 32'h1, "wipe flagged");
    power_up();
    chk({31'h0, wipe}, 32'h0, "wipe cleared on power on");
    $display("test emergency done");
    do_reset(1'b1);
    chk({31'h0, lna}, 32'h0, "strap high gain");
    rd_st(6'b000000, "status after second reset");
    $display("test second reset done");
    end_sim();
  end
endmodule
